/* design/fsp_addr_map.sv */
// Purpose: flash self-programming address decode and command sequencer
// Assumes: CPU gives pointer and one-cycle store/load strobes
// Notes: flash array reports completion on flash_done_in
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "fsp_params.svh"
module fsp_addr_map import fsp_pkg::*; #(
    parameter bit WIDE14 = 1'b0
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic boot_size_fuse_hi_in,
    input wire logic boot_size_fuse_lo_in,
    input wire logic [15:0] pointer_in,
    input wire logic store_in,
    input wire logic load_in,
    input wire logic flash_done_in,
    input wire logic [11:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic bvalid_out,
    output logic [1:0] bresp_out,
    input wire logic bready_in,
    input wire logic [11:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic rvalid_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    input wire logic rready_in,
    output logic [7:0] page_select_field_out,
    output logic [5:0] word_select_field_out,
    output logic byte_sel_out,
    output logic [13:0] load_addr_out,
    output logic load_go_out,
    output logic load_blocked_out,
    output logic page_write_out,
    output logic page_erase_out,
    output logic buffer_fill_out,
    output logic section_busy_flag_out,
    output logic store_enable_bit_out,
    output logic [13:0] boot_start_out
);
    fsp_state_s s_ff; // Registered state
    fsp_state_s nxt_s; // Next state
    logic [1:0] fuse; // Boot-size fuse pair
    logic [13:0] zword; // Pointer as flash word address
    logic in_rww; // Pointer lies in read-while-write section
    logic aw_t; // Write address taken
    logic w_t; // Write data taken
    logic do_wr; // Both halves present
    logic [4:0] cbits; // Low control bits written

    // Boot section start from fuse pair and variant
    function automatic logic [13:0] boot_start(input logic wide, input logic [1:0] f);
        logic [13:0] r;
        r = 14'h0000;
        if (wide) begin
            case (f)
                2'b11: r = `FSP_B14_3;
                2'b10: r = `FSP_B14_2;
                2'b01: r = `FSP_B14_1;
                default: r = `FSP_B14_0;
            endcase
        end else begin
            case (f)
                2'b11: r = `FSP_B13_3;
                2'b10: r = `FSP_B13_2;
                2'b01: r = `FSP_B13_1;
                default: r = `FSP_B13_0;
            endcase
        end
        return r;
    endfunction

    // Address decode shared by store and load paths
    always_comb begin
        fuse = {boot_size_fuse_hi_in, boot_size_fuse_lo_in};
        // Top pointer bits dropped per variant
        zword = WIDE14 ? {pointer_in[14:1]} : {1'b0, pointer_in[13:1]};
        in_rww = WIDE14 ? (zword < `FSP_NRWW14) : (zword < `FSP_NRWW13);
        aw_t = awvalid_in && s_ff.aw_rdy;
        w_t = wvalid_in && s_ff.w_rdy;
        do_wr = (s_ff.aw_ok || aw_t) && (s_ff.w_ok || w_t) && !s_ff.bv;
        // Low five control bits of the pending write
        cbits = w_t ? wdata_in[4:0] : s_ff.wd[4:0];
    end

    // Next-state logic for sequencer and bus slave
    always_comb begin
        nxt_s = s_ff;
        nxt_s.wr_pg = 1'b0;
        nxt_s.er_pg = 1'b0;
        nxt_s.fill = 1'b0;
        nxt_s.rd_go = 1'b0;
        nxt_s.rd_blk = 1'b0;
        nxt_s.boot = boot_start(WIDE14, fuse);
        // Write channel capture
        if (aw_t) begin
            nxt_s.aw_ok = 1'b1;
            nxt_s.wa = awaddr_in;
        end
        if (w_t) begin
            nxt_s.w_ok = 1'b1;
            nxt_s.wd = wdata_in;
        end
        // Sequencer
        case (s_ff.st)
            FSP_IDLE: begin
                nxt_s.page_write_command_bit = 1'b0;
                nxt_s.pgers = 1'b0;
                nxt_s.rwwre = 1'b0;
            end
            FSP_ARMED: begin
                if (store_in) begin
                    // Word address fields latched from pointer
                    nxt_s.page = WIDE14 ? pointer_in[14:7] : {1'b0, pointer_in[13:7]};
                    nxt_s.word = pointer_in[6:1];
                    if (s_ff.page_write_command_bit || s_ff.pgers) begin
                        nxt_s.wr_pg = s_ff.page_write_command_bit;
                        nxt_s.er_pg = s_ff.pgers;
                        nxt_s.st = FSP_BUSY;
                        if (in_rww) begin
                            nxt_s.sec_busy = 1'b1;
                        end
                    end else if (s_ff.rwwre) begin
                        // Re-enable section after completion
                        nxt_s.sec_busy = 1'b0;
                        nxt_s.st = FSP_IDLE;
                    end else begin
                        // Plain store loads the page buffer
                        nxt_s.fill = 1'b1;
                        nxt_s.sec_busy = 1'b0;
                        nxt_s.st = FSP_IDLE;
                    end
                end else if (s_ff.win == 3'h1) begin
                    // No store in time: command lapses
                    nxt_s.st = FSP_IDLE;
                end else begin
                    nxt_s.win = s_ff.win - 3'h1;
                end
            end
            FSP_BUSY: begin
                if (flash_done_in) begin
                    nxt_s.st = FSP_IDLE;
                end
            end
            default: nxt_s.st = FSP_IDLE;
        endcase
        // Control write: only legal combinations, never while busy
        if (do_wr) begin
            nxt_s.aw_ok = 1'b0;
            nxt_s.w_ok = 1'b0;
            nxt_s.bv = 1'b1;
            nxt_s.br = `FSP_OKAY;
            if ((aw_t ? awaddr_in : s_ff.wa) == `FSP_CTRL_OFS) begin
                if (s_ff.st != FSP_BUSY && (w_t ? wstrb_in[0] : 1'b1) &&
                    (cbits == 5'b00001 || cbits == 5'b00101 ||
                     cbits == 5'b00011 || cbits == 5'b10001)) begin
                    nxt_s.st = FSP_ARMED;
                    nxt_s.win = `FSP_WINDOW_CYC;
                    nxt_s.page_write_command_bit = cbits[`FSP_PAGE_WRITE_COMMAND_BIT_BIT];
                    nxt_s.pgers = cbits[`FSP_PGERS_BIT];
                    nxt_s.rwwre = cbits[`FSP_RWWRE_BIT];
                end
            end else if ((aw_t ? awaddr_in : s_ff.wa) != `FSP_STAT_OFS) begin
                nxt_s.br = `FSP_SLVERR;
            end
        end
        if (s_ff.bv && bready_in) begin
            nxt_s.bv = 1'b0;
        end
        nxt_s.aw_rdy = !nxt_s.aw_ok && !nxt_s.bv;
        nxt_s.w_rdy = !nxt_s.w_ok && !nxt_s.bv;
        // Read channel
        if (arvalid_in && s_ff.ar_rdy) begin
            nxt_s.rv = 1'b1;
            nxt_s.rr = `FSP_OKAY;
            nxt_s.rd = 32'h0000_0000;
            if (araddr_in == `FSP_CTRL_OFS) begin
                nxt_s.rd[4:0] = {s_ff.rwwre, 1'b0, s_ff.page_write_command_bit, s_ff.pgers, s_ff.st != FSP_IDLE};
                nxt_s.rd[6] = s_ff.sec_busy;
            end else if (araddr_in == `FSP_STAT_OFS) begin
                nxt_s.rd[13:0] = s_ff.boot;
                nxt_s.rd[23:16] = s_ff.page;
                nxt_s.rd[29:24] = s_ff.word;
                nxt_s.rd[31:30] = s_ff.st;
            end else begin
                nxt_s.rr = `FSP_SLVERR;
            end
        end else if (s_ff.rv && rready_in) begin
            nxt_s.rv = 1'b0;
        end
        nxt_s.ar_rdy = !nxt_s.rv;
        // Store-enable flag registered so the pin comes from a flop
        nxt_s.spm_en = (nxt_s.st != FSP_IDLE);
        // Program-memory load: byte select and section blocking
        if (load_in) begin
            nxt_s.rd_addr = zword;
            nxt_s.byte_sel = pointer_in[0];
            if (in_rww && s_ff.sec_busy) begin
                nxt_s.rd_blk = 1'b1;
            end else begin
                nxt_s.rd_go = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register
    assign awready_out = s_ff.aw_rdy;
    assign wready_out = s_ff.w_rdy;
    assign bvalid_out = s_ff.bv;
    assign bresp_out = s_ff.br;
    assign arready_out = s_ff.ar_rdy;
    assign rvalid_out = s_ff.rv;
    assign rdata_out = s_ff.rd;
    assign rresp_out = s_ff.rr;
    assign page_select_field_out = s_ff.page;
    assign word_select_field_out = s_ff.word;
    assign byte_sel_out = s_ff.byte_sel;
    assign load_addr_out = s_ff.rd_addr;
    assign load_go_out = s_ff.rd_go;
    assign load_blocked_out = s_ff.rd_blk;
    assign page_write_out = s_ff.wr_pg;
    assign page_erase_out = s_ff.er_pg;
    assign buffer_fill_out = s_ff.fill;
    assign section_busy_flag_out = s_ff.sec_busy;
    assign store_enable_bit_out = s_ff.spm_en;
    assign boot_start_out = s_ff.boot;

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    sequence armed_wr_s;
        s_ff.st == FSP_ARMED && s_ff.page_write_command_bit && store_in;
    endsequence
    boot_decode_a: assert property (!$past(srst_in) |-> boot_start_out == boot_start(WIDE14, $past(fuse)))
        else $error("boot start mismatch");
    window_len_a: assert property ($rose(s_ff.st == FSP_ARMED) && !store_in |-> ##[1:4] s_ff.st != FSP_ARMED)
        else $error("command window too long");
    page_write_a: assert property (armed_wr_s |=> page_write_out && s_ff.st == FSP_BUSY)
        else $error("page write not issued");
    page_field_a: assert property (armed_wr_s |=> page_select_field_out ==
        (WIDE14 ? $past(pointer_in[14:7]) : {1'b0, $past(pointer_in[13:7])}))
        else $error("page select wrong");
    word_field_a: assert property (buffer_fill_out |-> word_select_field_out == $past(pointer_in[6:1]))
        else $error("word select wrong");
    busy_set_a: assert property (
        s_ff.st == FSP_ARMED && (s_ff.page_write_command_bit || s_ff.pgers) && store_in && in_rww |=> section_busy_flag_out)
        else $error("busy flag not set");
    read_block_a: assert property (load_in && in_rww && section_busy_flag_out |=> load_blocked_out && !load_go_out)
        else $error("read not blocked");
    byte_sel_a: assert property (load_in |=> byte_sel_out == $past(pointer_in[0]))
        else $error("byte select wrong");
    split_a: assert property (load_in && !section_busy_flag_out |=> load_go_out ##0
        load_addr_out[13] == (WIDE14 ? $past(pointer_in[14]) : 1'b0))
        else $error("load address wrong");
    // Plain store while armed with no command bit
    sequence plain_store_s;
        s_ff.st == FSP_ARMED && !s_ff.page_write_command_bit && !s_ff.pgers && !s_ff.rwwre && store_in;
    endsequence
    // Buffer fill releases the busy section
    fill_clear_a: assert property (plain_store_s |=> buffer_fill_out && !section_busy_flag_out)
        else $error("fill did not release section");
    // Window runs out on its last edge without a store
    lapse_a: assert property (
        s_ff.st == FSP_ARMED && s_ff.win == 3'h1 && !store_in && !do_wr |=> !store_enable_bit_out)
        else $error("window did not lapse");
    // Loads outside the busy section always go ahead
    no_read_while_write_section_open_a: assert property (load_in && !in_rww |=> load_go_out && !load_blocked_out)
        else $error("locked section read refused");
    // Erase or write holds until the array reports done
    busy_hold_a: assert property (s_ff.st == FSP_BUSY && !flash_done_in |=> store_enable_bit_out)
        else $error("busy state left early");
endmodule

/* design/fsp_params.svh */
// Purpose: constants for the flash self-programming address map
// Assumes: one 125 MHz clock, 8 ns period
// Notes: offsets are byte addresses on the register bus
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
// Register offsets
`define FSP_CTRL_OFS 12'h000
`define FSP_STAT_OFS 12'h004
// Control field positions
`define FSP_STORE_ENABLE_BIT_BIT 0
`define FSP_PGERS_BIT 1
`define FSP_PAGE_WRITE_COMMAND_BIT_BIT 2
`define FSP_RWWRE_BIT 4
// Command window in clock cycles
`define FSP_WINDOW_CYC 3'h4
// Boot section starts, 13-bit variant, fuse 11,10,01,00
`define FSP_B13_3 14'h1F80
`define FSP_B13_2 14'h1F00
`define FSP_B13_1 14'h1E00
`define FSP_B13_0 14'h1C00
// Boot section starts, 14-bit variant
`define FSP_B14_3 14'h3F00
`define FSP_B14_2 14'h3E00
`define FSP_B14_1 14'h3C00
`define FSP_B14_0 14'h3800
// First no-read-while-write word per variant
`define FSP_NRWW13 14'h1C00
`define FSP_NRWW14 14'h3800
// Response codes
`define FSP_OKAY 2'h0
`define FSP_SLVERR 2'h2
`endif

/* design/fsp_pkg.sv */
// Purpose: types for the flash self-programming address map
// Assumes: constants come from fsp_params.svh
// Notes: whole block state is one packed struct
package fsp_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        FSP_IDLE = 2'b00,
        FSP_ARMED = 2'b01,
        FSP_BUSY = 2'b10
    } fsp_state_e;
    // Complete register state of the block
    typedef struct packed {
        fsp_state_e st;
        logic spm_en;
        logic page_write_command_bit;
        logic pgers;
        logic rwwre;
        logic [2:0] win;
        logic sec_busy;
        logic [7:0] page;
        logic [5:0] word;
        logic byte_sel;
        logic [13:0] rd_addr;
        logic rd_go;
        logic rd_blk;
        logic wr_pg;
        logic er_pg;
        logic fill;
        logic [13:0] boot;
        logic aw_rdy;
        logic w_rdy;
        logic aw_ok;
        logic w_ok;
        logic [11:0] wa;
        logic [31:0] wd;
        logic bv;
        logic [1:0] br;
        logic ar_rdy;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } fsp_state_s;
endpackage

/* verif/fsp_cpu_model.sv */
// Purpose: CPU core model issuing store and load program strobes
// Assumes: spm is called just after a rising edge, others wait for one
// Notes: pointer is scrambled between strobes so stale values show up
`timescale 1ns/1ps
module fsp_cpu_model (
    input wire logic clock_in,
    output logic store_out,
    output logic load_out,
    output logic done_out,
    output logic [15:0] ptr_out
);
    // Idle levels at start
    initial begin
        store_out = 1'b0;
        load_out = 1'b0;
        done_out = 1'b0;
        ptr_out = 16'h0000;
    end
    // Store strobe with the byte bit forced low
    task automatic spm(input logic [15:0] p);
        store_out <= 1'b1;
        ptr_out <= p & 16'hFFFE;
        @(posedge clock_in);
        store_out <= 1'b0;
        ptr_out <= ~p;
    endtask
    // Load strobe, byte bit passed through
    task automatic lpm(input logic [15:0] p);
        @(posedge clock_in);
        load_out <= 1'b1;
        ptr_out <= p;
        @(posedge clock_in);
        load_out <= 1'b0;
        ptr_out <= ~p;
    endtask
    // Flash array completion pulse
    task automatic done();
        @(posedge clock_in);
        done_out <= 1'b1;
        @(posedge clock_in);
        done_out <= 1'b0;
    endtask
endmodule

/* verif/flash_selfprog_addr_map_tb.sv */
// Purpose: self-checking bench for the flash address map
// Assumes: 125 MHz clock, variant picked by W14
// Notes: expected values follow W14 and the section tables
`timescale 1ns/1ps
`include "fsp_params.svh"
module flash_selfprog_addr_map_tb;
    localparam bit W14 = 1'b0; // Variant under test
    // Read-while-write page 0x6E, word 0, top bits set to be ignored
    localparam logic [15:0] P_RWW = W14 ? 16'hB700 : 16'hF700;
    localparam logic [15:0] P_NO_READ_WHILE_WRITE_SECTION = W14 ? 16'h7000 : 16'h3800; // First locked page
    localparam logic [55:0] BOOT = W14 ? {14'h3F00, 14'h3E00, 14'h3C00, 14'h3800}
                                       : {14'h1F80, 14'h1F00, 14'h1E00, 14'h1C00};
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic boot_size_fuse_hi_in = 1'b1;
    logic boot_size_fuse_lo_in = 1'b1;
    logic [15:0] pointer_in;
    logic store_in, load_in, flash_done_in;
    logic [11:0] awaddr_in = 12'h000;
    logic [11:0] araddr_in = 12'h000;
    logic [31:0] wdata_in = 32'h0;
    logic [3:0] wstrb_in = 4'hF;
    logic awvalid_in = 1'b0;
    logic wvalid_in = 1'b0;
    logic arvalid_in = 1'b0;
    logic bready_in = 1'b1;
    logic rready_in = 1'b1;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic [1:0] bresp_out, rresp_out, rsp;
    logic [31:0] rdata_out, rd_v;
    logic [7:0] page_select_field_out;
    logic [5:0] word_select_field_out;
    logic byte_sel_out, load_go_out, load_blocked_out, page_write_out, page_erase_out;
    logic buffer_fill_out, section_busy_flag_out, store_enable_bit_out;
    logic [13:0] load_addr_out, boot_start_out;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    fsp_addr_map #(.WIDE14(W14)) dut (.clock_in, .srst_in, .boot_size_fuse_hi_in, .boot_size_fuse_lo_in,
        .pointer_in, .store_in, .load_in, .flash_done_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in,
        .wstrb_in, .wvalid_in, .wready_out, .bvalid_out, .bresp_out, .bready_in, .araddr_in, .arvalid_in,
        .arready_out, .rvalid_out, .rdata_out, .rresp_out, .rready_in, .page_select_field_out,
        .word_select_field_out, .byte_sel_out, .load_addr_out, .load_go_out, .load_blocked_out,
        .page_write_out, .page_erase_out, .buffer_fill_out, .section_busy_flag_out, .store_enable_bit_out,
        .boot_start_out);
    fsp_cpu_model cpu (.clock_in, .store_out(store_in), .load_out(load_in), .done_out(flash_done_in),
        .ptr_out(pointer_in));
    // Clock, 8 ns period
    always #4 clock_in = ~clock_in;
    // Hang guard
    always @(posedge clock_in) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            err_count = err_count + 1;
            results();
        end
    end
    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks = checks + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Bus write, both halves offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_in);
        awaddr_in <= a;
        wdata_in <= d;
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        do begin
            @(posedge clock_in);
            if (awready_out) awvalid_in <= 1'b0;
            if (wready_out) wvalid_in <= 1'b0;
        end while (!bvalid_out);
        rsp = bresp_out;
    endtask
    // Bus read
    task automatic rd(input logic [11:0] a);
        @(posedge clock_in);
        araddr_in <= a;
        arvalid_in <= 1'b1;
        do begin
            @(posedge clock_in);
            if (arready_out) arvalid_in <= 1'b0;
        end while (!rvalid_out);
        rd_v = rdata_out;
        rsp = rresp_out;
    endtask
    // Strobes, outputs looked at once settled
    task automatic st(input logic [15:0] p);
        cpu.spm(p);
        #1;
    endtask
    task automatic ld(input logic [15:0] p);
        cpu.lpm(p);
        #1;
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Test sequence
    initial begin
        repeat (16) @(posedge clock_in);
        srst_in <= 1'b0;
        // Boot start for every fuse pair
        for (int f = 0; f < 4; f++) begin
            @(posedge clock_in);
            {boot_size_fuse_hi_in, boot_size_fuse_lo_in} <= f[1:0];
            repeat (2) @(posedge clock_in);
            #1 chk("boot_start", BOOT[f*14 +: 14], boot_start_out);
        end
        rd(`FSP_STAT_OFS);
        chk("stat_boot", BOOT[55:42], rd_v[13:0]);
        rd(12'h010);
        chk("rd_unmapped", 2, rsp);
        wr(12'h010, 32'h5);
        chk("wr_unmapped", 2, rsp);
        $display("test boot and bus done");
        // Erase then write to a read-while-write page
        for (int i = 0; i < 2; i++) begin
            wr(`FSP_CTRL_OFS, i ? 32'h05 : 32'h03);
            st(P_RWW);
            chk("page_write", i, page_write_out);
            chk("page_erase", !i, page_erase_out);
            chk("page_sel", 8'h6E, page_select_field_out);
            chk("busy_set", 1, section_busy_flag_out);
            ld(P_RWW);
            chk("blocked", 1, load_blocked_out);
            cpu.done();
            wr(`FSP_CTRL_OFS, 32'h11);
            st(16'h0000);
            @(posedge clock_in);
            #1 chk("busy_clr", 0, section_busy_flag_out);
        end
        ld(P_RWW | 16'h0001);
        chk("load_go", 1, load_go_out);
        chk("byte_sel", 1, byte_sel_out);
        chk("load_addr", 14'h1B80, load_addr_out);
        $display("test program and load done");
        // Buffer fill picks the word field
        wr(`FSP_CTRL_OFS, 32'h01);
        st(P_RWW | 16'h0054);
        chk("fill", 1, buffer_fill_out);
        chk("word_sel", 6'h2A, word_select_field_out);
        // Store after the window has lapsed
        wr(`FSP_CTRL_OFS, 32'h05);
        repeat (6) @(posedge clock_in);
        #1 chk("armed_lapse", 0, store_enable_bit_out);
        st(P_NO_READ_WHILE_WRITE_SECTION);
        chk("late_write", 0, page_write_out);
        // Write to the locked section leaves reads open
        wr(`FSP_CTRL_OFS, 32'h05);
        st(P_NO_READ_WHILE_WRITE_SECTION);
        chk("no_read_while_write_section_write", 1, page_write_out);
        chk("no_read_while_write_section_busy", 0, section_busy_flag_out);
        chk("no_read_while_write_section_page", W14 ? 8'hE0 : 8'h70, page_select_field_out);
        // Command while busy is refused, control reads back the running write
        wr(`FSP_CTRL_OFS, 32'h03);
        rd(`FSP_CTRL_OFS);
        chk("ctrl_busy", 32'h05, rd_v);
        cpu.done();
        // Illegal combination never arms the store
        wr(`FSP_CTRL_OFS, 32'h07);
        #1 chk("illegal_cmd", 0, store_enable_bit_out);
        $display("test fill window and split done");
        results();
    end
endmodule
